// ===== include/plut_pkg.sv
// Constants for the palette lookup block: register map, fields, resets.
// Assumes one 100 MHz clock and a byte-wide register port.
// Notes on behaviour
// RQ1: Three staging bytes hold six-bit colour components.
// RQ2: Staging writes never touch palette until commit.
// RQ3: Write pointer selects entry receiving staged components.
// RQ4: Both pointer registers read back as zero.
// RQ5: Read pointer write alone loads read-back registers.
// RQ6: Three read-back bytes present six-bit components.
// RQ7: Pixel value is used directly as index.
// RQ8: Component values pass linearly, larger means lighter.
// RQ9: Colour depth limits how many entries are used.
// RQ10: Sixteen bit pixels bypass the palette entirely.
// RQ11: Monochrome output uses only the green component.
// RQ12: Host and display accesses never corrupt each other.
package plut_pkg;
	// ==========================================
	// Widths
	localparam int COMP_W = 6;
	localparam int IDX_W = 8;
	localparam int ENTRY_W = 3 * COMP_W;
	localparam int DEPTH = 256;
	localparam int PIX_W = 16;

	// ==========================================
	// Register offsets
	localparam logic [7:0] OFS_STAGE_BLUE = 8'h08;
	localparam logic [7:0] OFS_STAGE_GREEN = 8'h09;
	localparam logic [7:0] OFS_STAGE_RED = 8'h0a;
	localparam logic [7:0] OFS_WRITE_PTR = 8'h0b;
	localparam logic [7:0] OFS_RB_BLUE = 8'h0c;
	localparam logic [7:0] OFS_RB_GREEN = 8'h0d;
	localparam logic [7:0] OFS_RB_RED = 8'h0e;
	localparam logic [7:0] OFS_READ_PTR = 8'h0f;
	localparam logic [7:0] OFS_DISPLAY_CTRL = 8'h10;

	// ==========================================
	// Display control fields
	localparam int CTRL_COLOUR_BIT = 6;
	localparam int CTRL_DEPTH_LSB = 0;
	localparam int CTRL_DEPTH_W = 3;
	localparam logic [2:0] DEPTH_1BPP = 3'h0;
	localparam logic [2:0] DEPTH_2BPP = 3'h1;
	localparam logic [2:0] DEPTH_4BPP = 3'h2;
	localparam logic [2:0] DEPTH_8BPP = 3'h3;
	localparam logic [2:0] DEPTH_16BPP = 3'h4;

	// ==========================================
	// Reset values and fixed answers
	localparam logic [COMP_W-1:0] COMP_RST = 6'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [IDX_W-1:0] IDX_RST = 8'h00;
	localparam logic [PIX_W-1:0] PIX_RST = 16'h0000;
endpackage

// ===== hw/plut_ram.sv
// Palette storage: one write port, two registered read ports.
// Assumes the caller applies clock enable and fixed-width words.
`timescale 1ns/1ps
`default_nettype none
module plut_ram (
	input wire logic i_clk,
	input wire logic i_ce,
	input wire logic i_we,
	input wire logic [plut_pkg::IDX_W-1:0] i_waddr,
	input wire logic [plut_pkg::ENTRY_W-1:0] i_wdata,
	input wire logic i_a_re,
	input wire logic [plut_pkg::IDX_W-1:0] i_a_addr,
	output logic [plut_pkg::ENTRY_W-1:0] o_a_data,
	input wire logic i_b_re,
	input wire logic [plut_pkg::IDX_W-1:0] i_b_addr,
	output logic [plut_pkg::ENTRY_W-1:0] o_b_data
);
	import plut_pkg::*;

	// ==========================================
	// Storage
	// Separate ports let display lookups run every cycle; a read of the
	// entry being written returns the old whole word, never a mix.
	logic [ENTRY_W-1:0] mem [DEPTH];

	always_ff @(posedge i_clk) begin
		if (i_ce && i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_ce && i_a_re) begin
			o_a_data <= mem[i_a_addr];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_ce && i_b_re) begin
			o_b_data <= mem[i_b_addr];
		end
	end
endmodule
`default_nettype wire

// ===== hw/plut_top.sv
// Palette lookup: indirect host access plus the display colour lookup.
// Assumes register strobes and pixels come from logic on i_clk.
`timescale 1ns/1ps
`default_nettype none
module plut_top (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_pix_valid,
	input wire logic [plut_pkg::PIX_W-1:0] i_pix_data,
	output logic o_pix_valid,
	output logic [plut_pkg::COMP_W-1:0] o_pix_red,
	output logic [plut_pkg::COMP_W-1:0] o_pix_green,
	output logic [plut_pkg::COMP_W-1:0] o_pix_blue
);
	import plut_pkg::*;

	// ==========================================
	// Declarations
	logic [COMP_W-1:0] staged_blue_component_reg;
	logic [COMP_W-1:0] staged_green_component_reg;
	logic [COMP_W-1:0] staged_red_component_reg;
	logic [COMP_W-1:0] readback_blue_component_reg;
	logic [COMP_W-1:0] readback_green_component_reg;
	logic [COMP_W-1:0] readback_red_component_reg;
	logic [7:0] ctrl_reg;
	logic commit_reg;
	logic [IDX_W-1:0] palette_write_index_reg;
	logic [ENTRY_W-1:0] commit_data_reg;
	logic rb_pend_reg;
	logic [ENTRY_W-1:0] host_rd_data;
	logic [ENTRY_W-1:0] pix_rd_data;
	logic [IDX_W-1:0] pix_idx;
	logic [2:0] depth;
	logic colour_mode;
	logic wr_stage_b;
	logic wr_stage_g;
	logic wr_stage_r;
	logic wr_wptr;
	logic wr_rptr;
	logic wr_ctrl;
	logic s1_valid_reg;
	logic s1_bypass_reg;
	logic s1_mono_reg;
	logic [PIX_W-1:0] s1_pix_reg;
	logic [7:0] rdata_next;
	logic [COMP_W-1:0] rb_blue_view;
	logic [COMP_W-1:0] rb_green_view;
	logic [COMP_W-1:0] rb_red_view;

	assign depth = ctrl_reg[CTRL_DEPTH_LSB +: CTRL_DEPTH_W];
	assign colour_mode = ctrl_reg[CTRL_COLOUR_BIT];
	assign wr_stage_b = i_wr && (i_addr == OFS_STAGE_BLUE);
	assign wr_stage_g = i_wr && (i_addr == OFS_STAGE_GREEN);
	assign wr_stage_r = i_wr && (i_addr == OFS_STAGE_RED);
	assign wr_wptr = i_wr && (i_addr == OFS_WRITE_PTR);
	assign wr_rptr = i_wr && (i_addr == OFS_READ_PTR);
	assign wr_ctrl = i_wr && (i_addr == OFS_DISPLAY_CTRL);

	// ==========================================
	// Staging registers
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			staged_blue_component_reg <= COMP_RST;
			staged_green_component_reg <= COMP_RST;
			staged_red_component_reg <= COMP_RST;
		end else if (i_ce) begin
			if (wr_stage_b) begin
				staged_blue_component_reg <= i_wdata[COMP_W-1:0]; // [RQ1]
			end
			if (wr_stage_g) begin
				staged_green_component_reg <= i_wdata[COMP_W-1:0]; // [RQ1]
			end
			if (wr_stage_r) begin
				staged_red_component_reg <= i_wdata[COMP_W-1:0]; // [RQ1]
			end
		end
	end

	// ==========================================
	// Commit on write pointer
	// The triplet is latched with the pointer so a staging write in the
	// very next cycle cannot leak into the entry being committed.
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			commit_reg <= 1'b0;
			palette_write_index_reg <= IDX_RST;
			commit_data_reg <= '0;
		end else if (i_ce) begin
			commit_reg <= wr_wptr; // [RQ2]
			if (wr_wptr) begin
				palette_write_index_reg <= i_wdata; // [RQ3]
				commit_data_reg <= {staged_red_component_reg, staged_green_component_reg,
					staged_blue_component_reg}; // [RQ12]
			end
		end
	end

	// ==========================================
	// Read-back registers
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rb_pend_reg <= 1'b0;
		end else if (i_ce) begin
			rb_pend_reg <= wr_rptr;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			readback_blue_component_reg <= COMP_RST;
			readback_green_component_reg <= COMP_RST;
			readback_red_component_reg <= COMP_RST;
		end else if (i_ce && rb_pend_reg) begin
			readback_blue_component_reg <= host_rd_data[COMP_W-1:0]; // [RQ5]
			readback_green_component_reg <= host_rd_data[2*COMP_W-1:COMP_W]; // [RQ5]
			readback_red_component_reg <= host_rd_data[3*COMP_W-1:2*COMP_W]; // [RQ5]
		end
	end

	// A read straight after the pointer write sees the fresh entry
	assign rb_blue_view = rb_pend_reg ? host_rd_data[COMP_W-1:0] : readback_blue_component_reg;
	assign rb_green_view = rb_pend_reg ? host_rd_data[2*COMP_W-1:COMP_W] : readback_green_component_reg;
	assign rb_red_view = rb_pend_reg ? host_rd_data[3*COMP_W-1:2*COMP_W] : readback_red_component_reg;

	// ==========================================
	// Display control
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ctrl_reg <= CTRL_RST;
		end else if (i_ce && wr_ctrl) begin
			ctrl_reg <= BYTE_ZERO;
			ctrl_reg[CTRL_COLOUR_BIT] <= i_wdata[CTRL_COLOUR_BIT];
			ctrl_reg[CTRL_DEPTH_LSB +: CTRL_DEPTH_W] <= i_wdata[CTRL_DEPTH_LSB +: CTRL_DEPTH_W];
		end
	end

	// ==========================================
	// Register read port
	always_comb begin
		rdata_next = BYTE_ZERO;
		unique case (i_addr)
			OFS_STAGE_BLUE: rdata_next = {2'b00, staged_blue_component_reg};
			OFS_STAGE_GREEN: rdata_next = {2'b00, staged_green_component_reg};
			OFS_STAGE_RED: rdata_next = {2'b00, staged_red_component_reg};
			OFS_RB_BLUE: rdata_next = {2'b00, rb_blue_view}; // [RQ6]
			OFS_RB_GREEN: rdata_next = {2'b00, rb_green_view}; // [RQ6]
			OFS_RB_RED: rdata_next = {2'b00, rb_red_view}; // [RQ6]
			OFS_WRITE_PTR: rdata_next = BYTE_ZERO; // [RQ4]
			OFS_READ_PTR: rdata_next = BYTE_ZERO; // [RQ4]
			OFS_DISPLAY_CTRL: rdata_next = ctrl_reg;
			default: rdata_next = BYTE_ZERO;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rdata <= BYTE_ZERO;
		end else if (i_ce) begin
			o_rdata <= i_rd ? rdata_next : BYTE_ZERO;
		end
	end

	// ==========================================
	// Pixel index by colour depth
	// Upper index bits are forced low so only the first 2, 4, 16 entries
	// can be reached at the small depths.
	always_comb begin
		pix_idx = IDX_RST;
		unique case (depth)
			DEPTH_1BPP: pix_idx = {7'h00, i_pix_data[0]}; // [RQ9]
			DEPTH_2BPP: pix_idx = {6'h00, i_pix_data[1:0]}; // [RQ9]
			DEPTH_4BPP: pix_idx = {4'h0, i_pix_data[3:0]}; // [RQ9]
			default: pix_idx = i_pix_data[IDX_W-1:0]; // [RQ7]
		endcase
	end

	// ==========================================
	// Palette storage
	// Host and display own separate read ports; writes are whole words
	plut_ram u_ram (
		.i_clk(i_clk),
		.i_ce(i_ce),
		.i_we(commit_reg), // [RQ12]
		.i_waddr(palette_write_index_reg),
		.i_wdata(commit_data_reg),
		.i_a_re(i_pix_valid),
		.i_a_addr(pix_idx),
		.o_a_data(pix_rd_data),
		.i_b_re(wr_rptr),
		.i_b_addr(i_wdata),
		.o_b_data(host_rd_data)
	);

	// ==========================================
	// Display pipeline
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s1_valid_reg <= 1'b0;
			s1_bypass_reg <= 1'b0;
			s1_mono_reg <= 1'b0;
			s1_pix_reg <= PIX_RST;
		end else if (i_ce) begin
			s1_valid_reg <= i_pix_valid;
			s1_bypass_reg <= (depth == DEPTH_16BPP); // [RQ10]
			s1_mono_reg <= !colour_mode;
			s1_pix_reg <= i_pix_data;
		end
	end

	// Palette components pass untouched and direct red and blue gain a low zero bit, so a larger code always stays lighter
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_pix_valid <= 1'b0;
			o_pix_red <= COMP_RST;
			o_pix_green <= COMP_RST;
			o_pix_blue <= COMP_RST;
		end else if (i_ce) begin
			o_pix_valid <= s1_valid_reg;
			if (s1_bypass_reg) begin
				o_pix_green <= s1_pix_reg[10:5]; // [RQ10]
				o_pix_red <= s1_mono_reg ? COMP_RST : {s1_pix_reg[15:11], 1'b0};
				o_pix_blue <= s1_mono_reg ? COMP_RST : {s1_pix_reg[4:0], 1'b0};
			end else begin
				o_pix_green <= pix_rd_data[2*COMP_W-1:COMP_W]; // [RQ8]
				o_pix_red <= s1_mono_reg ? COMP_RST : pix_rd_data[3*COMP_W-1:2*COMP_W]; // [RQ11]
				o_pix_blue <= s1_mono_reg ? COMP_RST : pix_rd_data[COMP_W-1:0]; // [RQ11]
			end
		end
	end

	// ==========================================
	// Assertions
	sequence wptr_write_s;
		i_ce && wr_wptr;
	endsequence

	sequence rptr_write_s;
		i_ce && wr_rptr;
	endsequence

	sequence rb_capture_s;
		i_ce && rb_pend_reg;
	endsequence

	property stage_load_p;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && wr_stage_g |=> staged_green_component_reg == $past(i_wdata[5:0]);
	endproperty

	stage_load_a: assert property (stage_load_p) // [RQ1]
		else $error("green staging did not load written value");

	stage_hold_a: assert property ( // [RQ2]
		@(posedge i_clk) disable iff (!i_rst_n)
		commit_reg && $past(i_ce) |-> $past(wr_wptr))
		else $error("palette written without a write pointer access");

	commit_index_a: assert property ( // [RQ3]
		@(posedge i_clk) disable iff (!i_rst_n)
		wptr_write_s |=> commit_reg && palette_write_index_reg == $past(i_wdata))
		else $error("commit index differs from written pointer");

	ptr_reads_zero_a: assert property ( // [RQ4]
		@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && i_rd && (i_addr == OFS_WRITE_PTR || i_addr == OFS_READ_PTR) |=> o_rdata == 8'h00)
		else $error("pointer register read was not zero");

	readback_copy_a: assert property ( // [RQ5]
		@(posedge i_clk) disable iff (!i_rst_n)
		rptr_write_s ##1 rb_capture_s |=> readback_green_component_reg == $past(host_rd_data[11:6]))
		else $error("read-back green not copied from entry");

	readback_hold_a: assert property ( // [RQ5]
		@(posedge i_clk) disable iff (!i_rst_n)
		!rb_pend_reg |=> $stable(readback_red_component_reg) && $stable(readback_blue_component_reg))
		else $error("read-back changed without read pointer write");

	readback_upper_a: assert property ( // [RQ6]
		@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && i_rd && i_addr == OFS_RB_BLUE |=> o_rdata[7:6] == 2'b00)
		else $error("read-back unused bits not zero");

	index_depth_a: assert property ( // [RQ9]
		@(posedge i_clk) disable iff (!i_rst_n)
		i_pix_valid && depth == DEPTH_4BPP |-> pix_idx == {4'h0, i_pix_data[3:0]})
		else $error("index not limited to sixteen entries");

	bypass_path_a: assert property ( // [RQ10]
		@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && s1_bypass_reg && !s1_mono_reg |=> o_pix_red[5:1] == $past(s1_pix_reg[15:11]))
		else $error("sixteen bit red not passed around palette");

	mono_green_a: assert property ( // [RQ11]
		@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && s1_valid_reg && s1_mono_reg && !s1_bypass_reg
		|=> o_pix_red == 6'h00 && o_pix_blue == 6'h00 && o_pix_green == $past(pix_rd_data[11:6]))
		else $error("monochrome output not green only");

	atomic_commit_a: assert property ( // [RQ12]
		@(posedge i_clk) disable iff (!i_rst_n)
		commit_reg |-> commit_data_reg == {$past(staged_red_component_reg),
			$past(staged_green_component_reg), $past(staged_blue_component_reg)})
		else $error("committed triplet not the staged one");

	pixel_latency_a: assert property ( // [RQ7]
		@(posedge i_clk) disable iff (!i_rst_n)
		i_ce && i_pix_valid ##1 i_ce |=> o_pix_valid)
		else $error("pixel result not valid two cycles later");
endmodule
`default_nettype wire

// ===== tb/plut_top_test.sv
// Self-checking bench for the palette lookup block: register port tasks and pixel lookups.
// Assumes the design keeps the one-cycle read answer and two-cycle pixel latency of its contract.
`timescale 1ns/1ps
`default_nettype none
module plut_top_test;
	import plut_pkg::*;
	logic i_clk, i_rst_n, i_ce, i_wr, i_rd, i_pix_valid;
	logic [7:0] i_addr, i_wdata, o_rdata;
	logic [PIX_W-1:0] i_pix_data;
	logic o_pix_valid;
	logic [COMP_W-1:0] o_pix_red, o_pix_green, o_pix_blue;
	int bad_count = 0;
	int total_checks = 0;

	plut_top u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pix_valid(i_pix_valid), .i_pix_data(i_pix_data),
		.o_pix_valid(o_pix_valid), .o_pix_red(o_pix_red), .o_pix_green(o_pix_green), .o_pix_blue(o_pix_blue));

	// ==========================================
	// Clock and closing
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic final_report();
		$display("Checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Every call below is made just after a rising edge and returns just after one
	task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask

	// Data must stand only in the cycle after the strobe, then fall back to zero
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		check($sformatf("rdata at %h", a), {10'h000, o_rdata}, {10'h000, exp});
		@(posedge i_clk);
		#1;
		check("rdata idle", {10'h000, o_rdata}, 18'h0_0000);
		@(posedge i_clk);
	endtask

	task automatic entry(input logic [7:0] idx, input logic [5:0] r, input logic [5:0] g, input logic [5:0] b);
		wr(OFS_STAGE_BLUE, {2'b00, b});
		wr(OFS_STAGE_GREEN, {2'b00, g});
		wr(OFS_STAGE_RED, {2'b00, r});
		wr(OFS_WRITE_PTR, idx);
	endtask

	task automatic readback(input logic [7:0] idx, input logic [5:0] r, input logic [5:0] g, input logic [5:0] b);
		wr(OFS_READ_PTR, idx);
		rd(OFS_RB_BLUE, {2'b00, b});
		rd(OFS_RB_GREEN, {2'b00, g});
		rd(OFS_RB_RED, {2'b00, r});
	endtask

	task automatic pix(input logic [15:0] p, input logic [5:0] r, input logic [5:0] g, input logic [5:0] b);
		i_pix_valid <= 1'b1;
		i_pix_data <= p;
		@(posedge i_clk);
		i_pix_valid <= 1'b0;
		@(posedge i_clk);
		#1;
		check("pix valid", {17'h0_0000, o_pix_valid}, 18'h0_0001);
		check($sformatf("pix %h", p), {o_pix_red, o_pix_green, o_pix_blue}, {r, g, b});
		@(posedge i_clk);
		#1;
		check("pix valid idle", {17'h0_0000, o_pix_valid}, 18'h0_0000);
		@(posedge i_clk);
	endtask

	// ==========================================
	// Watchdog: every wait is fixed, this only guards against a stalled run
	initial begin
		#200000;
		bad_count++;
		$display("Error watchdog expected finish seen hang");
		final_report();
	end

	// ==========================================
	// Main sequence
	initial begin
		i_rst_n = 1'b0;
		i_ce = 1'b1;
		i_addr = 8'h00;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_pix_valid = 1'b0;
		i_pix_data = PIX_RST;
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);

		// Reset state of the whole map plus an unmapped byte
		for (int a = 8; a <= 16; a++) begin
			rd(8'(a), 8'h00);
		end
		wr(8'h20, 8'h5a);
		rd(8'h20, 8'h00);
		$display("Test reset values done");

		// Upper two bits of each staging byte are not stored
		wr(OFS_STAGE_BLUE, 8'hff);
		rd(OFS_STAGE_BLUE, 8'h3f);
		wr(OFS_STAGE_GREEN, 8'hd5);
		rd(OFS_STAGE_GREEN, 8'h15);
		wr(OFS_STAGE_RED, 8'hea);
		rd(OFS_STAGE_RED, 8'h2a);
		$display("Test staging done");

		// Commit to boundary indices, then copy back entries 00, ff and 07
		entry(8'h00, 6'h01, 6'h02, 6'h03);
		entry(8'h01, 6'h3f, 6'h3f, 6'h3f);
		entry(8'h07, 6'h2a, 6'h15, 6'h0c);
		entry(8'hff, 6'h10, 6'h20, 6'h30);
		rd(OFS_WRITE_PTR, 8'h00);
		readback(8'h00, 6'h01, 6'h02, 6'h03);
		readback(8'hff, 6'h10, 6'h20, 6'h30);
		readback(8'h07, 6'h2a, 6'h15, 6'h0c);
		rd(OFS_READ_PTR, 8'h00);
		$display("Test commit and readback done");

		// Staging alone must not reach the table; commit alone must not load read-back
		wr(OFS_STAGE_BLUE, 8'h11);
		wr(OFS_STAGE_GREEN, 8'h22);
		readback(8'hff, 6'h10, 6'h20, 6'h30);
		wr(OFS_STAGE_RED, 8'h33);
		wr(OFS_WRITE_PTR, 8'hff);
		wr(OFS_RB_BLUE, 8'h01);
		rd(OFS_RB_BLUE, 8'h30);
		readback(8'hff, 6'h33, 6'h22, 6'h11);
		$display("Test staging isolation done");

		// Strobes are ignored while the clock enable is low
		i_ce <= 1'b0;
		wr(OFS_STAGE_BLUE, 8'h05);
		i_ce <= 1'b1;
		rd(OFS_STAGE_BLUE, 8'h11);
		$display("Test clock enable done");

		// Colour lookups at several depths, index taken from the low pixel bits
		wr(OFS_DISPLAY_CTRL, 8'h43);
		pix(16'h0007, 6'h2a, 6'h15, 6'h0c);
		pix(16'h00ff, 6'h33, 6'h22, 6'h11);
		pix(16'h0000, 6'h01, 6'h02, 6'h03);
		wr(OFS_DISPLAY_CTRL, 8'h40);
		pix(16'h0003, 6'h3f, 6'h3f, 6'h3f);
		wr(OFS_DISPLAY_CTRL, 8'h41);
		pix(16'h00fc, 6'h01, 6'h02, 6'h03);
		wr(OFS_DISPLAY_CTRL, 8'h42);
		pix(16'h00f7, 6'h2a, 6'h15, 6'h0c);
		// Gray output carries green only
		wr(OFS_DISPLAY_CTRL, 8'h03);
		pix(16'h0007, 6'h00, 6'h15, 6'h00);
		pix(16'h00ff, 6'h00, 6'h22, 6'h00);
		// Direct pixels bypass the table
		wr(OFS_DISPLAY_CTRL, 8'h44);
		pix(16'hf81f, 6'h3e, 6'h00, 6'h3e);
		pix(16'h07e0, 6'h00, 6'h3f, 6'h00);
		wr(OFS_DISPLAY_CTRL, 8'h04);
		pix(16'hffff, 6'h00, 6'h3f, 6'h00);
		$display("Test pixel lookup done");

		// A second reset clears the registers but leaves the table contents
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		rd(OFS_STAGE_RED, 8'h00);
		rd(OFS_RB_RED, 8'h00);
		rd(OFS_DISPLAY_CTRL, 8'h00);
		readback(8'h07, 6'h2a, 6'h15, 6'h0c);
		$display("Test second reset done");
		final_report();
	end
endmodule
`default_nettype wire
